// ---- hdl/fgs_pkg.sv ----
// Package with constants and types for the fuel gauge scheduler.
package fgs_pkg;

   // Timebase: the scheduler counts half-second ticks so that 7.5 s is a whole count.
   localparam int unsigned CLK_FREQ_HZ    = 10_000_000;
   localparam int unsigned TICK_PERIOD_MS = 500;
   localparam int unsigned TICK_CYCLES    = CLK_FREQ_HZ / 1000 * TICK_PERIOD_MS;

   // Active mode: 1 s sampling, 10 s update, in half-second ticks.
   localparam logic [10:0] ACT_SAMPLE_TICKS = 11'h002;
   localparam logic [10:0] ACT_UPDATE_TICKS = 11'h014;

   // Sleep mode pairs: 7.5 s/1 min, 15 s/4 min, 30 s/8 min, 60 s/16 min.
   localparam logic [10:0] SLP_SAMPLE_TICKS [4] = '{11'h00f, 11'h01e, 11'h03c, 11'h078};
   localparam logic [10:0] SLP_UPDATE_TICKS [4] = '{11'h078, 11'h1e0, 11'h3c0, 11'h780};
   localparam logic [1:0]  SLP_RATE_RESET       = 2'h0;

   // Sleep exit current thresholds selected by the two-bit field.
   localparam logic [11:0] SLEEP_EXIT_TH [4] = '{12'h020, 12'h040, 12'h080, 12'h100};

   // Low charge thresholds in percent.
   localparam logic [6:0]  LOW_CHARGE_TH [4] = '{7'h05, 7'h0a, 7'h0f, 7'h14};

   // Charge values.
   localparam logic [6:0]  SOC_FULL     = 7'h64;
   localparam logic [6:0]  SOC_RESET    = 7'h00;
   localparam logic [11:0] ACCUM_RESET  = 12'h000;
   localparam logic [7:0]  CAP_RESET    = 8'h00;

   // Step limit: base plus scaled current, the current part halved for a large pack.
   localparam logic [6:0]  STEP_BASE    = 7'h01;
   localparam logic [7:0]  CAP_LARGE    = 8'h80;

   // Derating shifts: reduction is capacity >> (base - proportion), or >> (base - proportion - 1) in the hotter half of the temperature band.
   localparam logic [3:0]  AGE_SHIFT_BASE  = 4'h7;
   localparam logic [3:0]  TEMP_SHIFT_BASE = 4'h6;

   localparam logic [1:0]  MODE_OFF    = 2'h0;
   localparam logic [1:0]  MODE_INIT   = 2'h1;
   localparam logic [1:0]  MODE_ACTIVE = 2'h2;
   localparam logic [1:0]  MODE_SLEEP  = 2'h3;

   typedef enum logic [1:0] {
      FGS_OFF,
      FGS_INIT,
      FGS_ACTIVE,
      FGS_SLEEP
   } fgs_state_t;

endpackage

// ---- hdl/fgs_tick_if.sv ----
// Interface carrying the timebase tick and its restart between modules.
`timescale 1ns/10ps
`default_nettype none
interface fgs_tick_if;
   logic restart;
   logic tick;
   modport src (input restart, output tick);
   modport snk (output restart, input tick);
endinterface
`default_nettype wire

// ---- hdl/fgs_timebase.sv ----
// Half-second tick generator with synchronous restart.
`timescale 1ns/10ps
`default_nettype none
module fgs_timebase #(
   parameter int unsigned TICK_CYCLES = fgs_pkg::TICK_CYCLES
) (
   // Clock and reset
   input  wire logic  clock_i,
   input  wire logic  rstn_i,
   // Tick link
   fgs_tick_if.src    tb
);

   logic [23:0] cnt_r;
   logic [23:0] cnt_nxt;
   logic        tick_r;
   logic        tick_nxt;

   always_comb begin
      cnt_nxt  = cnt_r + 24'h000001;
      tick_nxt = 1'b0;
      if (tb.restart) begin
         cnt_nxt = 24'h000000;
      end else if (cnt_r == 24'(TICK_CYCLES - 1)) begin
         cnt_nxt  = 24'h000000;
         tick_nxt = 1'b1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         cnt_r  <= 24'h000000;
         tick_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tb.tick = tick_r;

endmodule // fgs_timebase
`default_nettype wire

// ---- hdl/fgs_top.sv ----
// Fuel gauge scheduler: modes, sample timing, charge limiting, accumulation and derating.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Stay in shutdown until gauge enabled.
// - First value taken from voltage alone.
// - Follow the software active/sleep selection.
// - Active: sample 1 s, update 10 s.
// - Limit each step by current and capacity.
// - Sleep: four selectable sample/update pairs.
// - Sleep: converter powered only while sampling.
// - High current in sleep forces active.
// - 12-bit accumulator sums charging increases.
// - Units are percent points, 100 per cycle.
// - Wrap at 4096 and raise overflow flag.
// - Overflow may derate capacity by aging proportion.
// - Temperature derating needs both enable bits.
// - Hotter means smaller capacity, proportion selectable.
// - Temperature derating only inside thermistor band.
// - Low charge flag held while enabled.
// - Termination at full voltage reports 100%.
module fgs_top #(
   parameter int unsigned TICK_CYCLES = fgs_pkg::TICK_CYCLES
) (
   // Clock and reset
   input  wire logic         clock_i,
   input  wire logic         rstn_i,
   // Mode control
   input  wire logic         fg_enable_i,
   input  wire logic         sleep_mode_sel_i,
   input  wire logic [1:0]   sleep_rate_sel_i,
   input  wire logic [1:0]   sleep_exit_current_sel_i,
   // Converter results
   input  wire logic         adc_done_i,
   input  wire logic [6:0]   voltage_soc_i,
   input  wire logic [11:0]  instant_current_i,
   input  wire logic         charging_i,
   input  wire logic         charge_done_i,
   // Capacity configuration
   input  wire logic         capacity_load_i,
   input  wire logic [7:0]   battery_capacity_value_i,
   input  wire logic         aging_adjust_enable_i,
   input  wire logic [1:0]   aging_derate_proportion_i,
   input  wire logic         temp_adjust_enable_i,
   input  wire logic         thermistor_sense_enable_i,
   input  wire logic [1:0]   temp_derate_proportion_i,
   input  wire logic [11:0]  thermistor_node_i,
   input  wire logic [11:0]  temp_high_45_i,
   input  wire logic [11:0]  temp_low_0_i,
   // Flags
   input  wire logic [1:0]   low_charge_threshold_i,
   input  wire logic         low_charge_int_enable_i,
   input  wire logic         accum_flag_clear_i,
   // Converter control
   output logic              adc_start_o,
   output logic              adc_power_o,
   // Status
   output logic [1:0]        fg_mode_o,
   output logic [6:0]        charge_percent_value_o,
   output logic [3:0]        charge_accum_high_o,
   output logic [7:0]        charge_accum_low_o,
   output logic [7:0]        capacity_effective_o,
   output logic              accum_overflow_flag_o,
   output logic              low_charge_flag_o,
   output logic              int_event_o
);

   fgs_tick_if tick_link ();

   fgs_timebase #(.TICK_CYCLES(TICK_CYCLES)) u_timebase (
      .clock_i (clock_i),
      .rstn_i  (rstn_i),
      .tb      (tick_link)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Mode and schedule

   fgs_pkg::fgs_state_t state_r, state_nxt;
   logic [1:0]  mode_r, mode_nxt;
   logic [10:0] samp_cnt_r, samp_cnt_nxt;
   logic [10:0] upd_cnt_r, upd_cnt_nxt;
   logic        upd_due_r, upd_due_nxt;
   logic        busy_r, busy_nxt;
   logic        start_r, start_nxt;
   logic        power_r, power_nxt;
   logic        sel_prev_r;
   logic        restart;
   logic [10:0] samp_per;
   logic [10:0] upd_per;
   logic        over_th;

   assign over_th = instant_current_i > fgs_pkg::SLEEP_EXIT_TH[sleep_exit_current_sel_i];
   assign samp_per = (state_r == fgs_pkg::FGS_SLEEP) ?
                     fgs_pkg::SLP_SAMPLE_TICKS[sleep_rate_sel_i] : fgs_pkg::ACT_SAMPLE_TICKS;
   assign upd_per  = (state_r == fgs_pkg::FGS_SLEEP) ?
                     fgs_pkg::SLP_UPDATE_TICKS[sleep_rate_sel_i] : fgs_pkg::ACT_UPDATE_TICKS;

   always_comb begin
      state_nxt    = state_r;
      samp_cnt_nxt = samp_cnt_r;
      upd_cnt_nxt  = upd_cnt_r;
      upd_due_nxt  = upd_due_r;
      busy_nxt     = busy_r;
      start_nxt    = 1'b0;
      restart      = 1'b0;
      if (start_r) busy_nxt = 1'b1;
      if (adc_done_i) busy_nxt = 1'b0;
      case (state_r)
         fgs_pkg::FGS_OFF: begin
            if (fg_enable_i) begin
               state_nxt = fgs_pkg::FGS_INIT;
               start_nxt = 1'b1;
            end
         end
         fgs_pkg::FGS_INIT: begin
            if (adc_done_i && busy_r) begin
               state_nxt = sleep_mode_sel_i ? fgs_pkg::FGS_SLEEP : fgs_pkg::FGS_ACTIVE;
               restart   = 1'b1;
            end
         end
         fgs_pkg::FGS_ACTIVE, fgs_pkg::FGS_SLEEP: begin
            if (tick_link.tick) begin
               samp_cnt_nxt = samp_cnt_r + 11'h001;
               upd_cnt_nxt  = upd_cnt_r + 11'h001;
               if (samp_cnt_r + 11'h001 >= samp_per) begin
                  samp_cnt_nxt = 11'h000;
                  start_nxt    = 1'b1;
               end
               if (upd_cnt_r + 11'h001 >= upd_per) begin
                  upd_cnt_nxt = 11'h000;
                  upd_due_nxt = 1'b1;
               end
            end
            if (adc_done_i && busy_r) upd_due_nxt = 1'b0;
            if (state_r == fgs_pkg::FGS_SLEEP && adc_done_i && busy_r && over_th) begin
               state_nxt = fgs_pkg::FGS_ACTIVE;
               restart   = 1'b1;
            end
            // Only a change of the selection moves the mode, so that an automatic
            // exit from sleep is not undone while software still selects sleep.
            if (sleep_mode_sel_i != sel_prev_r) begin
               state_nxt = sleep_mode_sel_i ? fgs_pkg::FGS_SLEEP : fgs_pkg::FGS_ACTIVE;
               restart   = 1'b1;
            end
         end
         default: state_nxt = fgs_pkg::FGS_OFF;
      endcase
      if (restart) begin
         samp_cnt_nxt = 11'h000;
         upd_cnt_nxt  = 11'h000;
         upd_due_nxt  = 1'b0;
      end
      if (!fg_enable_i) begin
         state_nxt   = fgs_pkg::FGS_OFF;
         start_nxt   = 1'b0;
         busy_nxt    = 1'b0;
         upd_due_nxt = 1'b0;
      end
      case (state_nxt)
         fgs_pkg::FGS_INIT:   mode_nxt = fgs_pkg::MODE_INIT;
         fgs_pkg::FGS_ACTIVE: mode_nxt = fgs_pkg::MODE_ACTIVE;
         fgs_pkg::FGS_SLEEP:  mode_nxt = fgs_pkg::MODE_SLEEP;
         default:             mode_nxt = fgs_pkg::MODE_OFF;
      endcase
      // Active keeps the converter powered; sleep powers it only per sample.
      power_nxt = (state_nxt == fgs_pkg::FGS_ACTIVE) || start_nxt || busy_nxt;
   end

   assign tick_link.restart = restart;

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         state_r    <= fgs_pkg::FGS_OFF;
         mode_r     <= fgs_pkg::MODE_OFF;
         samp_cnt_r <= 11'h000;
         upd_cnt_r  <= 11'h000;
         upd_due_r  <= 1'b0;
         busy_r     <= 1'b0;
         start_r    <= 1'b0;
         power_r    <= 1'b0;
         sel_prev_r <= 1'b0;
      end else begin
         state_r    <= state_nxt;
         mode_r     <= mode_nxt;
         samp_cnt_r <= samp_cnt_nxt;
         upd_cnt_r  <= upd_cnt_nxt;
         upd_due_r  <= upd_due_nxt;
         busy_r     <= busy_nxt;
         start_r    <= start_nxt;
         power_r    <= power_nxt;
         sel_prev_r <= sleep_mode_sel_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Charge value, accumulator and flags

   logic [6:0]  soc_r, soc_nxt;
   logic [11:0] acc_r, acc_nxt;
   logic        acc_flag_r, acc_flag_nxt;
   logic        low_r, low_nxt;
   logic        irq_r, irq_nxt;
   logic        ovf;
   logic [6:0]  step_lim;
   logic [6:0]  rise;
   logic [12:0] acc_sum;
   logic        do_update;

   assign do_update = adc_done_i && busy_r && upd_due_r;
   // A large pack moves its charge slowly, so the current part of the step is halved.
   assign step_lim  = (capacity_effective_o >= fgs_pkg::CAP_LARGE) ?
                      (fgs_pkg::STEP_BASE + {3'h0, instant_current_i[11:8]}) :
                      (fgs_pkg::STEP_BASE + {2'h0, instant_current_i[11:7]});

   always_comb begin
      soc_nxt = soc_r;
      rise    = 7'h00;
      if (state_r == fgs_pkg::FGS_INIT && adc_done_i && busy_r) begin
         soc_nxt = voltage_soc_i;
      end else if (do_update) begin
         if (voltage_soc_i > soc_r) begin
            soc_nxt = (voltage_soc_i - soc_r > step_lim) ? soc_r + step_lim : voltage_soc_i;
         end else begin
            soc_nxt = (soc_r - voltage_soc_i > step_lim) ? soc_r - step_lim : voltage_soc_i;
         end
      end
      if (charge_done_i && state_r != fgs_pkg::FGS_OFF) soc_nxt = fgs_pkg::SOC_FULL;
      if (charging_i && soc_nxt > soc_r) rise = soc_nxt - soc_r;
      acc_sum = {1'b0, acc_r} + {6'h00, rise};
      acc_nxt = acc_sum[11:0];
      ovf     = acc_sum[12];
      // A new overflow beats a clear that lands in the same cycle.
      acc_flag_nxt = ovf || (acc_flag_r && !accum_flag_clear_i);
      low_nxt = low_charge_int_enable_i && state_r != fgs_pkg::FGS_OFF &&
                soc_r < fgs_pkg::LOW_CHARGE_TH[low_charge_threshold_i];
      irq_nxt = ovf || (low_nxt && !low_r);
   end

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         soc_r      <= fgs_pkg::SOC_RESET;
         acc_r      <= fgs_pkg::ACCUM_RESET;
         acc_flag_r <= 1'b0;
         low_r      <= 1'b0;
         irq_r      <= 1'b0;
      end else begin
         soc_r      <= soc_nxt;
         acc_r      <= acc_nxt;
         acc_flag_r <= acc_flag_nxt;
         low_r      <= low_nxt;
         irq_r      <= irq_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Capacity derating

   logic [7:0]  cap_age_r, cap_age_nxt;
   logic [7:0]  cap_eff_r, cap_eff_nxt;
   logic [3:0]  tshift;
   logic [11:0] tmid;
   logic        in_band;

   assign in_band = thermistor_node_i >= temp_high_45_i && thermistor_node_i <= temp_low_0_i;
   assign tmid    = temp_high_45_i + ((temp_low_0_i - temp_high_45_i) >> 1);

   always_comb begin
      cap_age_nxt = cap_age_r;
      if (capacity_load_i) begin
         cap_age_nxt = battery_capacity_value_i;
      end else if (ovf && aging_adjust_enable_i) begin
         cap_age_nxt = cap_age_r - (cap_age_r >> (fgs_pkg::AGE_SHIFT_BASE -
                                                  {2'h0, aging_derate_proportion_i}));
      end
      // The thermistor voltage falls as it warms, so the lower half of the band is
      // the hotter half and takes the larger cut.
      tshift = fgs_pkg::TEMP_SHIFT_BASE - {2'h0, temp_derate_proportion_i};
      if (thermistor_node_i < tmid) tshift = tshift - 4'h1;
      cap_eff_nxt = cap_age_r;
      if (temp_adjust_enable_i && thermistor_sense_enable_i && in_band) begin
         cap_eff_nxt = cap_age_r - (cap_age_r >> tshift);
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         cap_age_r <= fgs_pkg::CAP_RESET;
         cap_eff_r <= fgs_pkg::CAP_RESET;
      end else begin
         cap_age_r <= cap_age_nxt;
         cap_eff_r <= cap_eff_nxt;
      end
   end

   assign adc_start_o            = start_r;
   assign adc_power_o            = power_r;
   assign fg_mode_o              = mode_r;
   assign charge_percent_value_o = soc_r;
   assign charge_accum_high_o    = acc_r[11:8];
   assign charge_accum_low_o     = acc_r[7:0];
   assign capacity_effective_o   = cap_eff_r;
   assign accum_overflow_flag_o  = acc_flag_r;
   assign low_charge_flag_o      = low_r;
   assign int_event_o            = irq_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);

   a_off_when_disabled: assert property (!fg_enable_i |=> fg_mode_o == fgs_pkg::MODE_OFF)
      else $error("gauge not in shutdown while disabled");
   a_init_from_voltage: assert property (
      state_r == fgs_pkg::FGS_INIT && adc_done_i && busy_r && fg_enable_i && !charge_done_i
      |=> charge_percent_value_o == $past(voltage_soc_i))
      else $error("first value not taken from voltage");
   a_mode_follows_sel: assert property (
      fg_enable_i && state_r == fgs_pkg::FGS_ACTIVE && $rose(sleep_mode_sel_i)
      |=> fg_mode_o == fgs_pkg::MODE_SLEEP)
      else $error("sleep selection not followed");
   a_step_bounded: assert property (
      do_update && fg_enable_i && !charge_done_i && voltage_soc_i > soc_r
      |=> charge_percent_value_o - $past(soc_r) <= $past(step_lim))
      else $error("charge step exceeds limit");
   a_sleep_adc_off: assert property (
      state_r == fgs_pkg::FGS_SLEEP && !busy_r && !start_r ##1
      state_r == fgs_pkg::FGS_SLEEP && !start_r && !busy_r |-> !adc_power_o)
      else $error("converter powered between sleep samples");
   a_sleep_exit_hi: assert property (
      state_r == fgs_pkg::FGS_SLEEP && adc_done_i && busy_r && over_th && fg_enable_i &&
      sleep_mode_sel_i == sel_prev_r |=> fg_mode_o == fgs_pkg::MODE_ACTIVE)
      else $error("no automatic exit from sleep");
   a_accum_wraps: assert property (ovf |=> accum_overflow_flag_o && int_event_o &&
      {charge_accum_high_o, charge_accum_low_o} < 12'h064)
      else $error("overflow did not wrap and flag");
   a_full_on_done: assert property (
      charge_done_i && fg_enable_i && state_r != fgs_pkg::FGS_OFF
      |=> charge_percent_value_o == fgs_pkg::SOC_FULL)
      else $error("termination does not report full");
   a_low_flag_gated: assert property (low_charge_flag_o |-> $past(low_charge_int_enable_i))
      else $error("low flag set while disabled");
   a_temp_derate_dir: assert property (
      temp_adjust_enable_i && thermistor_sense_enable_i && in_band && !capacity_load_i
      ##1 !ovf |=> capacity_effective_o <= $past(cap_age_r))
      else $error("derated capacity exceeds base");
   a_sample_period: assert property (
      state_r == fgs_pkg::FGS_ACTIVE && fg_enable_i && !restart |-> samp_cnt_r < 11'h002)
      else $error("active sample counter past one second");

   c_enter_active: cover property (fg_mode_o == fgs_pkg::MODE_INIT ##1
                                   fg_mode_o == fgs_pkg::MODE_ACTIVE);
   c_sleep_exit: cover property (fg_mode_o == fgs_pkg::MODE_SLEEP ##1
                                 fg_mode_o == fgs_pkg::MODE_ACTIVE);
   c_overflow: cover property (ovf);
   c_low_flag: cover property ($rose(low_charge_flag_o));

endmodule // fgs_top
`default_nettype wire

// ---- verif/fgs_adc_model.sv ----
// Converter stand-in that answers each start with a done pulse and preset results.
`timescale 1ns/10ps
`default_nettype none
module fgs_adc_model (
   // Clock and converter control
   input  wire logic        clock_i,
   input  wire logic        adc_start_i,
   // Results to present and answer latency in cycles, at least one
   input  wire logic [6:0]  soc_set_i,
   input  wire logic [11:0] cur_set_i,
   input  wire logic [3:0]  lat_i,
   // Result lines
   output logic             adc_done_o,
   output logic [6:0]       voltage_soc_o,
   output logic [11:0]      instant_current_o
);
   logic [3:0] cnt_r = 4'h0;
   initial begin
      adc_done_o = 1'b0;
      voltage_soc_o = 7'h00;
      instant_current_o = 12'h000;
   end
   // Outside the done cycle the lines carry the inverse, so a sample taken late shows up.
   always @(negedge clock_i) begin
      adc_done_o        <= (cnt_r == 4'h1);
      voltage_soc_o     <= (cnt_r == 4'h1) ? soc_set_i : ~soc_set_i;
      instant_current_o <= (cnt_r == 4'h1) ? cur_set_i : ~cur_set_i;
      if (adc_start_i)
         cnt_r <= lat_i;
      else if (cnt_r != 4'h0)
         cnt_r <= cnt_r - 4'h1;
   end
endmodule // fgs_adc_model
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking testbench for the fuel gauge scheduler.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   localparam int TICKS = 4;
   logic        clock_i = 1'b0;
   logic        rstn_i = 1'b0;
   logic        fg_enable_i = 1'b0, sleep_mode_sel_i = 1'b0, charging_i = 1'b0;
   logic        charge_done_i = 1'b0, capacity_load_i = 1'b0, aging_adjust_enable_i = 1'b0;
   logic        temp_adjust_enable_i = 1'b0, thermistor_sense_enable_i = 1'b0;
   logic        low_charge_int_enable_i = 1'b1, accum_flag_clear_i = 1'b0;
   logic [1:0]  sleep_rate_sel_i = 2'h0, sleep_exit_current_sel_i = 2'h0;
   logic [1:0]  aging_derate_proportion_i = 2'h0, temp_derate_proportion_i = 2'h0;
   logic [1:0]  low_charge_threshold_i = 2'h0;
   logic [7:0]  battery_capacity_value_i = 8'h00;
   logic [11:0] thermistor_node_i = 12'h900, temp_high_45_i = 12'h100, temp_low_0_i = 12'h800;
   logic        adc_done_i, adc_start_o, adc_power_o, accum_overflow_flag_o;
   logic        low_charge_flag_o, int_event_o;
   logic [6:0]  voltage_soc_i, charge_percent_value_o;
   logic [11:0] instant_current_i;
   logic [1:0]  fg_mode_o;
   logic [3:0]  charge_accum_high_o;
   logic [7:0]  charge_accum_low_o, capacity_effective_o;
   logic [6:0]  soc_set = 7'h03;
   logic [11:0] cur_set = 12'h000;
   logic [3:0]  lat = 4'h1;
   int          mismatches = 0, checks = 0, exp_acc = 0, int_cnt = 0;
   logic [6:0]  prev_soc = 7'h00;

   always #50 clock_i = ~clock_i;

   fgs_top #(.TICK_CYCLES(TICKS)) fgs_top_i (
      .clock_i(clock_i), .rstn_i(rstn_i), .fg_enable_i(fg_enable_i),
      .sleep_mode_sel_i(sleep_mode_sel_i), .sleep_rate_sel_i(sleep_rate_sel_i),
      .sleep_exit_current_sel_i(sleep_exit_current_sel_i), .adc_done_i(adc_done_i),
      .voltage_soc_i(voltage_soc_i), .instant_current_i(instant_current_i),
      .charging_i(charging_i), .charge_done_i(charge_done_i),
      .capacity_load_i(capacity_load_i), .battery_capacity_value_i(battery_capacity_value_i),
      .aging_adjust_enable_i(aging_adjust_enable_i),
      .aging_derate_proportion_i(aging_derate_proportion_i),
      .temp_adjust_enable_i(temp_adjust_enable_i),
      .thermistor_sense_enable_i(thermistor_sense_enable_i),
      .temp_derate_proportion_i(temp_derate_proportion_i),
      .thermistor_node_i(thermistor_node_i), .temp_high_45_i(temp_high_45_i),
      .temp_low_0_i(temp_low_0_i), .low_charge_threshold_i(low_charge_threshold_i),
      .low_charge_int_enable_i(low_charge_int_enable_i),
      .accum_flag_clear_i(accum_flag_clear_i), .adc_start_o(adc_start_o),
      .adc_power_o(adc_power_o), .fg_mode_o(fg_mode_o),
      .charge_percent_value_o(charge_percent_value_o),
      .charge_accum_high_o(charge_accum_high_o), .charge_accum_low_o(charge_accum_low_o),
      .capacity_effective_o(capacity_effective_o),
      .accum_overflow_flag_o(accum_overflow_flag_o), .low_charge_flag_o(low_charge_flag_o),
      .int_event_o(int_event_o));

   fgs_adc_model fgs_adc_model_i (
      .clock_i(clock_i), .adc_start_i(adc_start_o), .soc_set_i(soc_set),
      .cur_set_i(cur_set), .lat_i(lat), .adc_done_o(adc_done_i),
      .voltage_soc_o(voltage_soc_i), .instant_current_o(instant_current_i));

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Expected accumulator: every rise of the reported charge while charging adds its points.
   always @(negedge clock_i) begin
      if (charging_i === 1'b1 && charge_percent_value_o > prev_soc)
         exp_acc += int'(charge_percent_value_o - prev_soc);
      if (int_event_o === 1'b1)
         int_cnt++;
      prev_soc = charge_percent_value_o;
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clock_i);
   endtask

   task automatic wait_start(input int lim, output int n);
      n = 0;
      do begin
         @(negedge clock_i);
         n++;
      end while (adc_start_o !== 1'b1 && n < lim);
   endtask

   task automatic wait_mode(input logic [1:0] m);
      int n;
      n = 0;
      while (fg_mode_o !== m && n < 3000) begin
         @(negedge clock_i);
         n++;
      end
      chk(16'(fg_mode_o), 16'(m));
   endtask

   task automatic wait_chg(output int n);
      logic [6:0] s;
      s = charge_percent_value_o;
      n = 0;
      do begin
         @(negedge clock_i);
         n++;
      end while (charge_percent_value_o === s && n < 400);
   endtask

   // Mode selection acts on a change only, so the request is dropped and raised again.
   task automatic toggle_sleep;
      sleep_mode_sel_i = 1'b0;
      cyc(4);
      sleep_mode_sel_i = 1'b1;
      wait_mode(fgs_pkg::MODE_SLEEP);
   endtask

   task automatic load_cap(input logic [7:0] c);
      battery_capacity_value_i = c;
      capacity_load_i = 1'b1;
      cyc(1);
      capacity_load_i = 1'b0;
      cyc(2);
   endtask

   task automatic final_report;
      $display("Counts: %0d checks, %0d mismatches", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge clock_i);
      mismatches++;
      final_report();
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      int n;
      logic [7:0] cool;
      cyc(8);
      rstn_i = 1'b1;
      wait_start(20, n);
      chk(16'(n), 16'd20);
      chk(16'(fg_mode_o), 16'(fgs_pkg::MODE_OFF));
      chk(16'(adc_power_o), 16'h0);
      $display("test shutdown done");
      fg_enable_i = 1'b1;
      soc_set = 7'h03;
      wait_mode(fgs_pkg::MODE_ACTIVE);
      chk(16'(charge_percent_value_o), 16'h3);
      chk(16'(low_charge_flag_o), 16'h1);
      low_charge_int_enable_i = 1'b0;
      cyc(3);
      chk(16'(low_charge_flag_o), 16'h0);
      $display("test init done");
      wait_start(100, n);
      wait_start(100, n);
      chk(16'(n), 16'(2 * TICKS));
      soc_set = 7'h5a;
      wait_chg(n);
      chk(16'(charge_percent_value_o), 16'h4);
      cur_set = 12'h080;
      wait_chg(n);
      chk(16'(n), 16'(20 * TICKS));
      chk(16'(charge_percent_value_o), 16'h6);
      load_cap(8'hc0);
      chk(16'(capacity_effective_o), 16'hc0);
      wait_chg(n);
      chk(16'(charge_percent_value_o), 16'h7);
      $display("test active done");
      temp_adjust_enable_i = 1'b1;
      for (int p = 0; p < 4; p++) begin
         temp_derate_proportion_i = 2'(p);
         cool = 8'hc0 - (8'hc0 >> (6 - p));
         thermistor_sense_enable_i = 1'b1;
         thermistor_node_i = 12'h800;
         cyc(10);
         chk(16'(capacity_effective_o), 16'(cool));
         thermistor_node_i = 12'h100;
         cyc(10);
         chk(16'(capacity_effective_o < cool), 16'h1);
         thermistor_node_i = 12'h900;
         cyc(10);
         chk(16'(capacity_effective_o), 16'hc0);
         thermistor_node_i = 12'h800;
         thermistor_sense_enable_i = 1'b0;
         cyc(10);
         chk(16'(capacity_effective_o), 16'hc0);
      end
      temp_adjust_enable_i = 1'b0;
      charge_done_i = 1'b1;
      cyc(3);
      chk(16'(charge_percent_value_o), 16'(fgs_pkg::SOC_FULL));
      charge_done_i = 1'b0;
      $display("test derating done");
      lat = 4'h5;
      cur_set = 12'h000;
      for (int r = 0; r < 4; r++) begin
         sleep_rate_sel_i = 2'(r);
         toggle_sleep();
         wait_start(3000, n);
         wait_start(3000, n);
         chk(16'(n), 16'(fgs_pkg::SLP_SAMPLE_TICKS[r] * TICKS));
         chk(16'(adc_power_o), 16'h1);
         cyc(10);
         chk(16'(adc_power_o), 16'h0);
      end
      sleep_rate_sel_i = 2'h0;
      for (int s = 0; s < 4; s++) begin
         sleep_exit_current_sel_i = 2'(s);
         cur_set = fgs_pkg::SLEEP_EXIT_TH[s];
         toggle_sleep();
         wait_start(3000, n);
         wait_start(3000, n);
         cyc(8);
         chk(16'(fg_mode_o), 16'(fgs_pkg::MODE_SLEEP));
         cur_set = fgs_pkg::SLEEP_EXIT_TH[s] + 12'h001;
         wait_start(3000, n);
         cyc(8);
         chk(16'(fg_mode_o), 16'(fgs_pkg::MODE_ACTIVE));
      end
      sleep_mode_sel_i = 1'b0;
      lat = 4'h1;
      $display("test sleep done");
      load_cap(8'h40);
      aging_adjust_enable_i = 1'b1;
      aging_derate_proportion_i = 2'h3;
      cur_set = 12'hfff;
      soc_set = 7'h00;
      int_cnt = 0;
      charging_i = 1'b1;
      while (exp_acc < 4100) begin
         if (charge_percent_value_o === fgs_pkg::SOC_FULL)
            soc_set = 7'h00;
         else if (charge_percent_value_o === 7'h00)
            soc_set = fgs_pkg::SOC_FULL;
         wait_chg(n);
      end
      cyc(1);
      charging_i = 1'b0;
      cyc(2);
      chk(16'({charge_accum_high_o, charge_accum_low_o}), 16'(exp_acc % 4096));
      chk(16'(accum_overflow_flag_o), 16'h1);
      chk(16'(int_cnt), 16'h1);
      chk(16'(capacity_effective_o), 16'h3c);
      accum_flag_clear_i = 1'b1;
      cyc(1);
      accum_flag_clear_i = 1'b0;
      cyc(1);
      chk(16'(accum_overflow_flag_o), 16'h0);
      fg_enable_i = 1'b0;
      cyc(2);
      chk(16'(fg_mode_o), 16'(fgs_pkg::MODE_OFF));
      $display("test accumulator done");
      final_report();
   end
endmodule // tb_top
`default_nettype wire
